// ---- design/rfs_regfile.sv ----
// Banked working registers, stack pointer and special-register decode
`timescale 1ns/1ps
`default_nettype none
module rfs_regfile (
  input  wire logic             clk_in,         // Core clock, 125 MHz
  input  wire logic             sys_rst_in,     // Synchronous reset, active high
  input  wire logic             cmd_valid_in,   // Operation request
  input  wire rfs_pkg::rfs_op_t cmd_op_in,      // Operation kind
  input  wire logic [7:0]       cmd_addr_in,    // Address, bit address or register index
  input  wire logic [7:0]       cmd_wdata_in,   // Write data, bit value in bit 0
  input  wire logic [15:0]      cmd_ret_in,     // Return address for a call
  output logic                  cmd_ready_out,  // Request may be taken
  output logic                  rsp_valid_out,  // Operation finished
  output logic [7:0]            rsp_data_out,   // Read data
  output logic [15:0]           rsp_ret_out,    // Return address popped
  output logic                  rsp_unmap_out,  // Unimplemented special register hit
  output logic [7:0]            sp_out,         // Stack pointer
  output logic [7:0]            psw_out,        // Program status word
  output logic [7:0]            acc_out,        // Accumulator
  output logic [7:0]            aux_out         // Auxiliary operand register
);
  logic [7:0]          sp_reg, sp_next, psw_reg, psw_next, acc_reg, acc_next;
  logic [7:0]          aux_reg, aux_next, data_reg, data_next, hold_reg, hold_next;
  logic [15:0]         ret_reg, ret_next;
  logic                ready_reg, ready_next, valid_reg, valid_next, unmap_reg, unmap_next;
  rfs_pkg::rfs_state_t state_reg, state_next;
  logic                wr_en, sfr_wr_en, sfr_hit, accept;
  logic [7:0]          wr_addr, wr_data, a_addr, a_data, b_addr, b_data;
  logic [7:0]          sfr_addr, sfr_rdata, sfr_wval, bit_byte;
  logic [1:0]          bank;

  function automatic logic [7:0] reg_addr(input logic [1:0] bk, input logic [2:0] idx);
    reg_addr = {3'h0, bk, idx};
  endfunction : reg_addr

  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] pos,
                                         input logic b);
    set_bit      = v;
    set_bit[pos] = b;
  endfunction : set_bit

  rfs_scratch_ram u_ram (
    .clk_in    (clk_in),
    .wr_en_in  (wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .a_addr_in (a_addr),
    .a_data_out(a_data),
    .b_addr_in (b_addr),
    .b_data_out(b_data)
  );

  assign bank   = psw_reg[rfs_pkg::PSW_BANK_HI:rfs_pkg::PSW_BANK_LO];
  assign accept = cmd_valid_in && ready_reg;

  // Bit address decode: low half into RAM bit area, high half to special registers
  always_comb begin
    bit_byte = rfs_pkg::BIT_AREA_BASE | {4'h0, cmd_addr_in[6:3]};
    if (cmd_op_in == rfs_pkg::OP_BIT_RD || cmd_op_in == rfs_pkg::OP_BIT_WR) begin
      sfr_addr = {cmd_addr_in[7:3], 3'h0};
    end else begin
      sfr_addr = cmd_addr_in;
    end
  end

  // Implemented special registers
  always_comb begin
    sfr_hit = 1'b1;
    unique case (sfr_addr)
      rfs_pkg::ADDR_SP:  sfr_rdata = sp_reg;
      rfs_pkg::ADDR_PSW: sfr_rdata = psw_reg;
      rfs_pkg::ADDR_ACC: sfr_rdata = acc_reg;
      rfs_pkg::ADDR_AUX: sfr_rdata = aux_reg;
      default: begin
        sfr_rdata = 8'h00;
        sfr_hit   = 1'b0;
      end
    endcase
  end

  always_comb begin
    sp_next    = sp_reg;
    psw_next   = psw_reg;
    acc_next   = acc_reg;
    aux_next   = aux_reg;
    data_next  = data_reg;
    hold_next  = hold_reg;
    ret_next   = ret_reg;
    state_next = state_reg;
    valid_next = 1'b0;
    unmap_next = 1'b0;
    wr_en      = 1'b0;
    wr_addr    = cmd_addr_in;
    wr_data    = cmd_wdata_in;
    a_addr     = cmd_addr_in;
    b_addr     = reg_addr(bank, {2'h0, cmd_addr_in[0]});
    sfr_wr_en  = 1'b0;
    sfr_wval   = cmd_wdata_in;
    unique case (state_reg)
      rfs_pkg::ST_IDLE: begin
        if (accept) begin
          valid_next = 1'b1;
          unique case (cmd_op_in)
            default: valid_next = 1'b0;
            rfs_pkg::OP_DIR_RD: begin
              if (cmd_addr_in[rfs_pkg::SFR_SPACE_BIT]) begin
                data_next  = sfr_rdata;
                unmap_next = !sfr_hit;
              end else begin
                data_next = a_data;
              end
            end
            rfs_pkg::OP_DIR_WR: begin
              if (cmd_addr_in[rfs_pkg::SFR_SPACE_BIT]) begin
                sfr_wr_en  = 1'b1;
                unmap_next = !sfr_hit;
              end else begin
                wr_en = 1'b1;
              end
            end
            rfs_pkg::OP_IND_RD: begin
              a_addr    = b_data;
              data_next = a_data;
            end
            rfs_pkg::OP_IND_WR: begin
              wr_addr = b_data;
              wr_en   = 1'b1;
            end
            rfs_pkg::OP_BIT_RD: begin
              if (cmd_addr_in[rfs_pkg::SFR_SPACE_BIT]) begin
                data_next  = {7'h00, sfr_rdata[cmd_addr_in[2:0]]};
                unmap_next = !sfr_hit;
              end else begin
                a_addr    = bit_byte;
                data_next = {7'h00, a_data[cmd_addr_in[2:0]]};
              end
            end
            rfs_pkg::OP_BIT_WR: begin
              if (cmd_addr_in[rfs_pkg::SFR_SPACE_BIT]) begin
                sfr_wr_en  = 1'b1;
                sfr_wval   = set_bit(sfr_rdata, cmd_addr_in[2:0], cmd_wdata_in[0]);
                unmap_next = !sfr_hit;
              end else begin
                a_addr  = bit_byte;
                wr_addr = bit_byte;
                wr_data = set_bit(a_data, cmd_addr_in[2:0], cmd_wdata_in[0]);
                wr_en   = 1'b1;
              end
            end
            rfs_pkg::OP_REG_RD: begin
              a_addr    = reg_addr(bank, cmd_addr_in[2:0]);
              data_next = a_data;
            end
            rfs_pkg::OP_REG_WR: begin
              wr_addr = reg_addr(bank, cmd_addr_in[2:0]);
              wr_en   = 1'b1;
            end
            rfs_pkg::OP_PUSH: begin
              sp_next = sp_reg + rfs_pkg::SP_STEP;
              wr_addr = sp_next;
              wr_en   = 1'b1;
            end
            rfs_pkg::OP_POP: begin
              a_addr    = sp_reg;
              data_next = a_data;
              sp_next   = sp_reg - rfs_pkg::SP_STEP;
            end
            rfs_pkg::OP_CALL: begin
              valid_next = 1'b0;
              sp_next    = sp_reg + rfs_pkg::SP_STEP;
              wr_addr    = sp_next;
              wr_data    = cmd_ret_in[7:0];
              wr_en      = 1'b1;
              hold_next  = cmd_ret_in[15:8];
              state_next = rfs_pkg::ST_CALL_HI;
            end
            rfs_pkg::OP_RET: begin
              valid_next     = 1'b0;
              a_addr         = sp_reg;
              ret_next[15:8] = a_data;
              sp_next        = sp_reg - rfs_pkg::SP_STEP;
              state_next     = rfs_pkg::ST_RET_LO;
            end
          endcase
        end
      end
      rfs_pkg::ST_CALL_HI: begin
        sp_next    = sp_reg + rfs_pkg::SP_STEP;
        wr_addr    = sp_next;
        wr_data    = hold_reg;
        wr_en      = 1'b1;
        valid_next = 1'b1;
        state_next = rfs_pkg::ST_IDLE;
      end
      rfs_pkg::ST_RET_LO: begin
        a_addr        = sp_reg;
        ret_next[7:0] = a_data;
        sp_next       = sp_reg - rfs_pkg::SP_STEP;
        valid_next    = 1'b1;
        state_next    = rfs_pkg::ST_IDLE;
      end
    endcase
    if (sfr_wr_en) begin
      unique case (sfr_addr)
        rfs_pkg::ADDR_SP:  sp_next  = sfr_wval;
        rfs_pkg::ADDR_PSW: psw_next = sfr_wval;
        rfs_pkg::ADDR_ACC: acc_next = sfr_wval;
        rfs_pkg::ADDR_AUX: aux_next = sfr_wval;
        default: ;
      endcase
    end
    ready_next = (state_next == rfs_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sp_reg    <= rfs_pkg::SP_RESET;
      psw_reg   <= rfs_pkg::PSW_RESET;
      acc_reg   <= rfs_pkg::ACC_RESET;
      aux_reg   <= rfs_pkg::AUX_RESET;
      data_reg  <= 8'h00;
      hold_reg  <= 8'h00;
      ret_reg   <= 16'h0000;
      ready_reg <= 1'b1;
      valid_reg <= 1'b0;
      unmap_reg <= 1'b0;
      state_reg <= rfs_pkg::ST_IDLE;
    end else begin
      sp_reg    <= sp_next;
      psw_reg   <= psw_next;
      acc_reg   <= acc_next;
      aux_reg   <= aux_next;
      data_reg  <= data_next;
      hold_reg  <= hold_next;
      ret_reg   <= ret_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
      unmap_reg <= unmap_next;
      state_reg <= state_next;
    end
  end

  assign cmd_ready_out = ready_reg;
  assign rsp_valid_out = valid_reg;
  assign rsp_data_out  = data_reg;
  assign rsp_ret_out   = ret_reg;
  assign rsp_unmap_out = unmap_reg;
  assign sp_out        = sp_reg;
  assign psw_out       = psw_reg;
  assign acc_out       = acc_reg;
  assign aux_out       = aux_reg;

  sequence seq_call_take;
    accept && cmd_op_in == rfs_pkg::OP_CALL;
  endsequence
  sequence seq_two_step_done;
    !cmd_ready_out ##1 (cmd_ready_out && rsp_valid_out);
  endsequence

  AST_RESET_SP: assert property (@(posedge clk_in)
    $past(sys_rst_in) |-> sp_out == rfs_pkg::SP_RESET)
    else $error("Stack pointer not 07h after reset");
  AST_PUSH_ORDER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_PUSH |-> wr_en && wr_addr == sp_out + 8'h01)
    else $error("Push did not store above the old pointer");
  AST_POP_ORDER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_POP |=>
      rsp_data_out == $past(a_data) && $past(a_addr) == $past(sp_out)
      && sp_out == $past(sp_out) - 8'h01)
    else $error("Pop read or decrement order wrong");
  AST_CALL_PUSH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    seq_call_take |=> seq_two_step_done ##0 sp_out == $past(sp_out, 2) + 8'h02)
    else $error("Call did not push two bytes");
  AST_RET_POP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_RET |=>
      seq_two_step_done ##0 sp_out == $past(sp_out, 2) - 8'h02)
    else $error("Return did not pop two bytes");
  AST_BANK_MAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_REG_WR |->
      wr_addr == {3'h0, psw_out[4:3], cmd_addr_in[2:0]})
    else $error("Working register not in active bank");
  AST_IND_PTR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_IND_RD |-> b_addr[7:1] == {3'h0, bank, 2'h0}
      && a_addr == b_data)
    else $error("Indirect access not through pointer register");
  AST_SP_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_DIR_WR && cmd_addr_in == rfs_pkg::ADDR_SP
      |=> sp_out == $past(cmd_wdata_in) && rsp_valid_out)
    else $error("Stack pointer write lost");
  AST_SFR_DIRECT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_DIR_WR && cmd_addr_in[7] |-> !wr_en)
    else $error("Special register write reached RAM");
  AST_BIT_AREA: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    accept && cmd_op_in == rfs_pkg::OP_BIT_WR && !cmd_addr_in[7] |->
      wr_addr >= 8'h20 && wr_addr <= 8'h2f)
    else $error("Bit write outside bit area");
endmodule : rfs_regfile
`default_nettype wire

// ---- design/rfs_pkg.sv ----
// Constants and types for the banked register file and stack block
package rfs_pkg;
  localparam int          DATA_W         = 8;
  localparam int          RAM_DEPTH      = 256;
  localparam logic [7:0]  SP_RESET       = 8'h07;
  localparam logic [7:0]  PSW_RESET      = 8'h00;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [7:0]  AUX_RESET      = 8'h00;
  localparam logic [7:0]  ADDR_SP        = 8'h81;
  localparam logic [7:0]  ADDR_PSW       = 8'hd0;
  localparam logic [7:0]  ADDR_ACC       = 8'he0;
  localparam logic [7:0]  ADDR_AUX       = 8'hf0;
  localparam logic [7:0]  BIT_AREA_BASE  = 8'h20;
  localparam int          SFR_SPACE_BIT  = 7;
  localparam int          PSW_BANK_HI    = 4;
  localparam int          PSW_BANK_LO    = 3;
  localparam logic [7:0]  SP_STEP        = 8'h01;

  typedef enum logic [3:0] {
    OP_NONE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR, OP_BIT_RD, OP_BIT_WR,
    OP_REG_RD, OP_REG_WR, OP_PUSH, OP_POP, OP_CALL, OP_RET
  } rfs_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CALL_HI, ST_RET_LO} rfs_state_t;
endpackage : rfs_pkg

// ---- design/rfs_scratch_ram.sv ----
// Scratch-pad RAM: one write port, two asynchronous read ports
`timescale 1ns/1ps
`default_nettype none
module rfs_scratch_ram (
  input  wire logic       clk_in,      // Core clock
  input  wire logic       wr_en_in,    // Write strobe
  input  wire logic [7:0] wr_addr_in,  // Write address
  input  wire logic [7:0] wr_data_in,  // Write data
  input  wire logic [7:0] a_addr_in,   // Read port A address
  output logic      [7:0] a_data_out,  // Read port A data
  input  wire logic [7:0] b_addr_in,   // Read port B address
  output logic      [7:0] b_data_out   // Read port B data
);
  logic [7:0] mem [rfs_pkg::RAM_DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  assign a_data_out = mem[a_addr_in];
  assign b_data_out = mem[b_addr_in];
endmodule : rfs_scratch_ram
`default_nettype wire

// ---- dv/rfs_cpu_model.sv ----
// Execution-side model that issues register file requests
`timescale 1ns/1ps
`default_nettype none
module rfs_cpu_model (
  input  wire logic             clk_in,        // Core clock
  output logic                  cmd_valid_out, // Request
  output var rfs_pkg::rfs_op_t  cmd_op_out,    // Operation kind
  output logic [7:0]            cmd_addr_out,  // Address or index
  output logic [7:0]            cmd_wdata_out, // Write data
  output logic [15:0]           cmd_ret_out,   // Return address
  input  wire logic             ready_in,      // Request may be taken
  input  wire logic             rsp_valid_in,  // Operation finished
  input  wire logic [7:0]       rsp_data_in,   // Read data
  input  wire logic [15:0]      rsp_ret_in,    // Popped return address
  input  wire logic             rsp_unmap_in   // Unimplemented hit
);
  logic [7:0]  rdata;
  logic [15:0] rret;
  logic        unmap;
  logic        late;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_op_out    = rfs_pkg::OP_NONE;
    cmd_addr_out  = 8'h00;
    cmd_wdata_out = 8'h00;
    cmd_ret_out   = 16'h0000;
    late          = 1'b0;
  end

  // Callers may also write unimplemented special addresses such as 90h
  task automatic run(input rfs_pkg::rfs_op_t op, input logic [7:0] addr,
                     input logic [7:0] wdata, input logic [15:0] ret);
    logic ok;
    int   n;
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_op_out    <= op;
    cmd_addr_out  <= addr;
    cmd_wdata_out <= wdata;
    cmd_ret_out   <= ret;
    n = 0;
    do begin
      #1;
      ok = ready_in;
      @(posedge clk_in);
      n++;
    end while (ok !== 1'b1 && n < 8);
    cmd_valid_out <= 1'b0;
    cmd_op_out    <= rfs_pkg::OP_NONE;
    // Released lines must not keep their last value
    cmd_addr_out  <= ~addr;
    cmd_wdata_out <= ~wdata;
    cmd_ret_out   <= ~ret;
    n = 0;
    #1;
    while (rsp_valid_in !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    late  = late | (rsp_valid_in !== 1'b1);
    rdata = rsp_data_in;
    rret  = rsp_ret_in;
    unmap = rsp_unmap_in;
  endtask : run
endmodule : rfs_cpu_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the banked register file and stack
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
  logic                 clk_in;
  logic                 sys_rst_in;
  logic                 v, rdy, rv, um;
  rfs_pkg::rfs_op_t     op;
  logic [7:0]           ad, wd, rd, sp_out, psw_out, acc_out, aux_out;
  logic [15:0]          rt, rr;
  int                   n_mismatch, checks, i, b;
  logic [7:0]           m_sp, m_psw, d, a;
  logic [15:0]          ret;
  logic [15:0]          ret_q[$];

  rfs_cpu_model u_cpu (.clk_in(clk_in), .cmd_valid_out(v), .cmd_op_out(op),
    .cmd_addr_out(ad), .cmd_wdata_out(wd), .cmd_ret_out(rt), .ready_in(rdy),
    .rsp_valid_in(rv), .rsp_data_in(rd), .rsp_ret_in(rr), .rsp_unmap_in(um));
  rfs_regfile u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(v),
    .cmd_op_in(op), .cmd_addr_in(ad), .cmd_wdata_in(wd), .cmd_ret_in(rt),
    .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rd), .rsp_ret_out(rr),
    .rsp_unmap_out(um), .sp_out(sp_out), .psw_out(psw_out), .acc_out(acc_out),
    .aux_out(aux_out));

  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    n_mismatch = 0;
    checks     = 0;
    sys_rst_in = 1'b1;
    b = $urandom(64711);
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    `CHK("sp reset", rfs_pkg::SP_RESET, sp_out)
    `CHK("aux reset", 8'h00, aux_out)
    // Bank selection and bank-to-RAM mapping
    for (i = 0; i < 16; i++) begin
      m_psw = {3'h0, 2'($urandom), 3'h0};
      u_cpu.run(rfs_pkg::OP_DIR_WR, rfs_pkg::ADDR_PSW, m_psw, 16'h0000);
      `CHK("psw write", m_psw, psw_out)
      a = 8'($urandom % 8);
      d = 8'($urandom);
      u_cpu.run(rfs_pkg::OP_REG_WR, a, d, 16'h0000);
      u_cpu.run(rfs_pkg::OP_DIR_RD, {3'h0, m_psw[4:3], a[2:0]}, 8'h00, 16'h0000);
      `CHK("bank byte", d, u_cpu.rdata)
      u_cpu.run(rfs_pkg::OP_REG_RD, a, 8'h00, 16'h0000);
      `CHK("reg read", d, u_cpu.rdata)
    end
    // Pointer registers reach upper RAM, not special registers
    for (i = 0; i < 8; i++) begin
      a = 8'($urandom) | 8'h80;
      d = 8'($urandom);
      u_cpu.run(rfs_pkg::OP_REG_WR, 8'(i % 2), a, 16'h0000);
      u_cpu.run(rfs_pkg::OP_IND_WR, 8'(i % 2), d, 16'h0000);
      u_cpu.run(rfs_pkg::OP_IND_RD, 8'(i % 2), 8'h00, 16'h0000);
      `CHK("indirect", d, u_cpu.rdata)
    end
    d = 8'($urandom);
    u_cpu.run(rfs_pkg::OP_DIR_WR, rfs_pkg::ADDR_AUX, d, 16'h0000);
    `CHK("aux write", d, aux_out)
    `CHK("aux unmap", 1'b0, u_cpu.unmap)
    u_cpu.run(rfs_pkg::OP_DIR_WR, 8'h90, d, 16'h0000);
    `CHK("unmap wr", 1'b1, u_cpu.unmap)
    u_cpu.run(rfs_pkg::OP_DIR_RD, 8'h90, 8'h00, 16'h0000);
    `CHK("unmap rd", 8'h00, u_cpu.rdata)
    // Bit access in RAM bit area and accumulator
    for (i = 0; i < 8; i++) begin
      b = $urandom % 128;
      d = 8'($urandom);
      u_cpu.run(rfs_pkg::OP_DIR_WR, 8'(32 + b / 8), d, 16'h0000);
      u_cpu.run(rfs_pkg::OP_BIT_WR, 8'(b), {7'h00, ~d[b % 8]}, 16'h0000);
      d[b % 8] = ~d[b % 8];
      u_cpu.run(rfs_pkg::OP_DIR_RD, 8'(32 + b / 8), 8'h00, 16'h0000);
      `CHK("bit area", d, u_cpu.rdata)
      u_cpu.run(rfs_pkg::OP_BIT_RD, 8'(b), 8'h00, 16'h0000);
      `CHK("bit read", 8'(d[b % 8]), u_cpu.rdata)
      u_cpu.run(rfs_pkg::OP_BIT_WR, 8'he0 + 8'(i), 8'h01, 16'h0000);
      `CHK("acc bit", 8'((2 ** (i + 1)) - 1), acc_out)
      u_cpu.run(rfs_pkg::OP_BIT_RD, 8'he0 + 8'(i), 8'h00, 16'h0000);
      `CHK("acc bit rd", 8'h01, u_cpu.rdata)
    end
    // Stack: push, pop, call and return, with wrap at the top
    for (i = 0; i < 6; i++) begin
      m_sp = (i < 2) ? 8'hfe : {2'h1, 6'($urandom)};
      d = 8'($urandom);
      u_cpu.run(rfs_pkg::OP_DIR_WR, rfs_pkg::ADDR_SP, m_sp, 16'h0000);
      `CHK("sp write", m_sp, sp_out)
      u_cpu.run(rfs_pkg::OP_PUSH, 8'h00, d, 16'h0000);
      m_sp = m_sp + 8'h01;
      `CHK("push sp", m_sp, sp_out)
      u_cpu.run(rfs_pkg::OP_REG_WR, 8'h01, m_sp, 16'h0000);
      u_cpu.run(rfs_pkg::OP_IND_RD, 8'h01, 8'h00, 16'h0000);
      `CHK("push byte", d, u_cpu.rdata)
      u_cpu.run(rfs_pkg::OP_POP, 8'h00, 8'h00, 16'h0000);
      m_sp = m_sp - 8'h01;
      `CHK("pop data", d, u_cpu.rdata)
      `CHK("pop sp", m_sp, sp_out)
      ret = 16'($urandom);
      ret_q.push_back(ret);
      u_cpu.run(rfs_pkg::OP_CALL, 8'h00, 8'h00, ret);
      `CHK("call sp", m_sp + 8'h02, sp_out)
      u_cpu.run(rfs_pkg::OP_POP, 8'h00, 8'h00, 16'h0000);
      `CHK("call hi", ret[15:8], u_cpu.rdata)
      u_cpu.run(rfs_pkg::OP_POP, 8'h00, 8'h00, 16'h0000);
      `CHK("call lo", ret[7:0], u_cpu.rdata)
      u_cpu.run(rfs_pkg::OP_PUSH, 8'h00, ret[7:0], 16'h0000);
      u_cpu.run(rfs_pkg::OP_PUSH, 8'h00, ret[15:8], 16'h0000);
      u_cpu.run(rfs_pkg::OP_RET, 8'h00, 8'h00, 16'h0000);
      ret = ret_q.pop_front();
      `CHK("ret addr", ret, u_cpu.rret)
      `CHK("ret sp", m_sp, sp_out)
    end
    `CHK("late", 1'b0, u_cpu.late)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
